/* core/lkd_pkg.sv */
// Constants, types and register map of the lock detector configuration block.
// Assumes a 50 MHz sys_clk and an AXI4-Lite master with 32-bit data.
// Functional notes
// - Bit 14 enables false lock detection
// - False lock overflow forces false lock state
// - Bit 13 picks stepped or continuous sweep
// - Bits 12-9 set verify length
// - Continuous: bits 8-5 count forced sweep
// - Stepped: bits 8-5 count sweep-enabled computes
// - Bit 4 picks host or machine control
// - Host control ignores accumulator rollover
// - Host control: stop each period, await restart
// - Bit 3 selects track or acquisition set
// - Bit 2 drives lock status bit
// - Host-to-machine switch with bit 2 locks
// - Bit 0 gates sweep into lag path
// - False lock only in verify, track set
package lkd_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] LKD_IDX_CONFIG = 8'h17;
	localparam logic [7:0] LKD_IDX_STATE = 8'h18;
	localparam logic [7:0] LKD_IDX_CMD = 8'h19;
	localparam logic [9:0] LKD_ADDR_CONFIG = {LKD_IDX_CONFIG, 2'b00};
	localparam logic [9:0] LKD_ADDR_STATE = {LKD_IDX_STATE, 2'b00};
	localparam logic [9:0] LKD_ADDR_CMD = {LKD_IDX_CMD, 2'b00};
	localparam logic [15:0] LKD_CONFIG_RESET = 16'h0000;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int LKD_BIT_FALSE_EN = 14;
	localparam int LKD_BIT_CONT_SWEEP = 13;
	localparam int LKD_VERIFY_MSB = 12;
	localparam int LKD_VERIFY_LSB = 9;
	localparam int LKD_SWEEP_MSB = 8;
	localparam int LKD_SWEEP_LSB = 5;
	localparam int LKD_BIT_MACHINE = 4;
	localparam int LKD_BIT_ACQ_SEL = 3;
	localparam int LKD_BIT_HOST_LOCK = 2;
	localparam int LKD_BIT_HOST_SWEEP = 0;
	localparam int LKD_BIT_CMD_RESTART = 0;
	localparam logic [15:0] LKD_CONFIG_MASK = 16'h7ffd;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		LKD_ACQUIRE,
		LKD_VERIFY,
		LKD_LOCKED,
		LKD_FALSE_LOCK,
		LKD_HOST_RUN,
		LKD_HOST_STOP
	} lkd_state_t;

endpackage

/* core/lkd_axi_slave.sv */
// AXI4-Lite slave holding the configuration word and a restart command.
// Assumes a master that keeps one write and one read at a time.
module lkd_axi_slave
	import lkd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [9:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [9:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] stateWord,
	output logic [15:0] configWord,
	output logic restartPulse
);

	logic awHeld_ff;
	logic wHeld_ff;
	logic [9:0] awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic [15:0] config_ff;
	logic bValid_ff;
	logic [1:0] bResp_ff;
	logic rValid_ff;
	logic [31:0] rData_ff;
	logic [1:0] rResp_ff;
	logic restart_ff;
	logic doWrite;

	assign s_axi_awready = !awHeld_ff && !bValid_ff;
	assign s_axi_wready = !wHeld_ff && !bValid_ff;
	assign s_axi_arready = !rValid_ff;
	assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
	assign s_axi_bvalid = bValid_ff;
	assign s_axi_bresp = bResp_ff;
	assign s_axi_rvalid = rValid_ff;
	assign s_axi_rdata = rData_ff;
	assign s_axi_rresp = rResp_ff;
	assign configWord = config_ff;
	assign restartPulse = restart_ff;

	// ----------------------------------------
	// Write address and data capture
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			awHeld_ff <= 1'b0;
			awAddr_ff <= 10'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld_ff <= 1'b1;
			awAddr_ff <= s_axi_awaddr;
		end else if (doWrite) begin
			awHeld_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wHeld_ff <= 1'b0;
			wData_ff <= 32'h0000_0000;
			wStrb_ff <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld_ff <= 1'b1;
			wData_ff <= s_axi_wdata;
			wStrb_ff <= s_axi_wstrb;
		end else if (doWrite) begin
			wHeld_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Register update and response
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			config_ff <= LKD_CONFIG_RESET;
		end else if (doWrite && awAddr_ff[9:2] == LKD_IDX_CONFIG) begin
			// Upper half dropped; reserved bits 15 and 1 held at zero
			if (wStrb_ff[0]) config_ff[7:0] <= wData_ff[7:0] & LKD_CONFIG_MASK[7:0];
			if (wStrb_ff[1]) config_ff[15:8] <= wData_ff[15:8] & LKD_CONFIG_MASK[15:8];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			restart_ff <= 1'b0;
		end else begin
			restart_ff <= doWrite && awAddr_ff[9:2] == LKD_IDX_CMD && wStrb_ff[0]
				&& wData_ff[LKD_BIT_CMD_RESTART];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bValid_ff <= 1'b0;
			bResp_ff <= 2'b00;
		end else if (doWrite) begin
			bValid_ff <= 1'b1;
			bResp_ff <= (awAddr_ff[9:2] == LKD_IDX_CONFIG || awAddr_ff[9:2] == LKD_IDX_CMD)
				? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			bValid_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rValid_ff <= 1'b0;
			rData_ff <= 32'h0000_0000;
			rResp_ff <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rValid_ff <= 1'b1;
			if (s_axi_araddr[9:2] == LKD_IDX_STATE) begin
				rData_ff <= stateWord;
				rResp_ff <= 2'b00;
			end else begin
				rData_ff <= 32'h0000_0000;
				rResp_ff <= 2'b10;
			end
		end else if (s_axi_rready) begin
			rValid_ff <= 1'b0;
		end
	end

endmodule

/* core/lkd_period_counter.sv */
// Down counter of integration periods or compute cycles.
// Assumes load and tick are same-clock single-cycle strobes.
module lkd_period_counter #(
	parameter int WIDTH = 4
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic load,
	input wire logic [WIDTH-1:0] loadValue,
	input wire logic tick,
	output logic [WIDTH-1:0] count,
	output logic zero
);

	logic [WIDTH-1:0] count_ff;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			count_ff <= '0;
		end else if (load) begin
			count_ff <= loadValue;
		end else if (tick && count_ff != '0) begin
			count_ff <= count_ff - 1'b1;
		end
	end

	assign count = count_ff;
	assign zero = (count_ff == '0);

endmodule

/* core/lkd_lock_detector.sv */
// Lock detector acquisition state machine with its configuration word.
// Assumes period end, lock, false lock overflow and compute strobes
// come from same-clock accumulator logic as one-cycle pulses.
//
// The AXI4-Lite register port was left to the implementer.
module lkd_lock_detector
	import lkd_pkg::*;
#(
	parameter int CNT_WIDTH = 4
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [9:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [9:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic periodEnd,
	input wire logic carrierLock,
	input wire logic lockRollover,
	input wire logic falseOverflow,
	input wire logic computeTick,
	output logic accumRun,
	output logic acqParamSel,
	output logic falseAccumEnable,
	output logic sweepRun,
	output logic lagSweepEnable,
	output logic lock_indication_output_bit
);

	logic [15:0] configWord;
	logic restartPulse;
	logic [31:0] stateWord;
	lkd_state_t state_ff;
	lkd_state_t nxt_state;
	logic machine_ff;
	logic [CNT_WIDTH-1:0] verifyCount;
	logic verifyZero;
	logic [CNT_WIDTH-1:0] sweepCount;
	logic sweepZero;
	logic sweepLoad;
	logic sweepTick;
	logic verifyLoad;
	logic verifyStep;
	logic sweepStep;
	logic stepSweep_ff;
	logic accumRun_ff;
	logic acqSel_ff;
	logic falseEn_ff;
	logic sweepRun_ff;
	logic lagSweep_ff;
	logic lockBit_ff;

	// ----------------------------------------
	// Configuration fields
	// ----------------------------------------
	logic falseEnable;
	logic contSweep;
	logic machineCtl;
	logic hostAcq;
	logic hostLock;
	logic hostSweep;
	logic [CNT_WIDTH-1:0] verifyLen;
	logic [CNT_WIDTH-1:0] sweepLen;

	assign falseEnable = configWord[LKD_BIT_FALSE_EN];
	assign contSweep = configWord[LKD_BIT_CONT_SWEEP];
	assign machineCtl = configWord[LKD_BIT_MACHINE];
	assign hostAcq = configWord[LKD_BIT_ACQ_SEL];
	assign hostLock = configWord[LKD_BIT_HOST_LOCK];
	assign hostSweep = configWord[LKD_BIT_HOST_SWEEP];
	assign verifyLen = configWord[LKD_VERIFY_MSB:LKD_VERIFY_LSB];
	assign sweepLen = configWord[LKD_SWEEP_MSB:LKD_SWEEP_LSB];

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// States in which the sweep block runs on the acquisition set
	function automatic logic sweepState(input lkd_state_t s);
		sweepState = (s == LKD_ACQUIRE) || (s == LKD_FALSE_LOCK);
	endfunction

	// Count ends at zero, or at one with a tick pending
	function automatic logic lastTick(input logic isZero, input logic tick,
		input logic [CNT_WIDTH-1:0] cnt);
		lastTick = isZero || (tick && cnt == CNT_WIDTH'(1));
	endfunction

	lkd_axi_slave u_axi (
		.sys_clk(sys_clk),
		.reset(reset),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.stateWord(stateWord),
		.configWord(configWord),
		.restartPulse(restartPulse)
	);

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	assign verifyLoad = (state_ff == LKD_ACQUIRE) && (nxt_state == LKD_VERIFY);
	assign sweepLoad = (state_ff != LKD_FALSE_LOCK) && (nxt_state == LKD_FALSE_LOCK);
	// Continuous counts integration periods, stepped counts computes
	assign sweepTick = contSweep ? periodEnd : computeTick;
	assign verifyStep = periodEnd && state_ff == LKD_VERIFY;
	assign sweepStep = sweepTick && state_ff == LKD_FALSE_LOCK;

	lkd_period_counter #(.WIDTH(CNT_WIDTH)) u_verify (
		.sys_clk(sys_clk),
		.reset(reset),
		.load(verifyLoad),
		.loadValue(verifyLen),
		.tick(verifyStep),
		.count(verifyCount),
		.zero(verifyZero)
	);

	lkd_period_counter #(.WIDTH(CNT_WIDTH)) u_sweep (
		.sys_clk(sys_clk),
		.reset(reset),
		.load(sweepLoad),
		.loadValue(sweepLen),
		.tick(sweepStep),
		.count(sweepCount),
		.zero(sweepZero)
	);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stepSweep_ff <= 1'b0;
		end else if (sweepLoad) begin
			stepSweep_ff <= !contSweep;
		end
	end

	// ----------------------------------------
	// Control owner tracking
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			machine_ff <= 1'b0;
		end else begin
			machine_ff <= machineCtl;
		end
	end

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		if (!machineCtl) begin
			// Host owns the loop: run a period, then hold until restart
			case (state_ff)
				LKD_HOST_RUN: begin
					if (periodEnd) nxt_state = LKD_HOST_STOP;
				end
				LKD_HOST_STOP: begin
					if (restartPulse) nxt_state = LKD_HOST_RUN;
				end
				default: nxt_state = LKD_HOST_RUN;
			endcase
		end else if (!machine_ff) begin
			// Hand-over from host: entry picked by host lock bit
			nxt_state = hostLock ? LKD_LOCKED : LKD_ACQUIRE;
		end else begin
			case (state_ff)
				LKD_ACQUIRE: begin
					if (periodEnd && carrierLock) nxt_state = LKD_VERIFY;
				end
				LKD_VERIFY: begin
					// Overflow beats lock loss, lock loss beats declare
					if (falseEnable && falseOverflow) begin
						nxt_state = LKD_FALSE_LOCK;
					end else if (periodEnd && !carrierLock) begin
						nxt_state = LKD_ACQUIRE;
					end else if (lastTick(verifyZero, periodEnd, verifyCount)) begin
						nxt_state = LKD_LOCKED;
					end
				end
				LKD_LOCKED: begin
					if (periodEnd && !carrierLock) nxt_state = LKD_ACQUIRE;
				end
				LKD_FALSE_LOCK: begin
					if (lastTick(sweepZero, sweepTick, sweepCount)) begin
						nxt_state = LKD_ACQUIRE;
					end
				end
				default: nxt_state = LKD_ACQUIRE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_ff <= LKD_HOST_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	// Accumulator halts only in host stop
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			accumRun_ff <= 1'b0;
		end else begin
			accumRun_ff <= nxt_state != LKD_HOST_STOP;
		end
	end

	// Host picks the set; verify always runs on track
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			acqSel_ff <= 1'b0;
		end else if (machineCtl) begin
			acqSel_ff <= sweepState(nxt_state);
		end else begin
			acqSel_ff <= hostAcq;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			falseEn_ff <= 1'b0;
		end else begin
			falseEn_ff <= machineCtl && falseEnable && nxt_state == LKD_VERIFY;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sweepRun_ff <= 1'b0;
		end else if (machineCtl) begin
			sweepRun_ff <= sweepState(nxt_state);
		end else begin
			sweepRun_ff <= hostSweep;
		end
	end

	// Machine sweeps the lag path only in stepped false lock
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			lagSweep_ff <= 1'b0;
		end else if (machineCtl) begin
			lagSweep_ff <= nxt_state == LKD_FALSE_LOCK
				&& (sweepLoad ? !contSweep : stepSweep_ff);
		end else begin
			lagSweep_ff <= hostSweep;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			lockBit_ff <= 1'b0;
		end else if (machineCtl) begin
			lockBit_ff <= nxt_state == LKD_LOCKED;
		end else begin
			lockBit_ff <= hostLock;
		end
	end

	assign accumRun = accumRun_ff;
	assign acqParamSel = acqSel_ff;
	assign falseAccumEnable = falseEn_ff;
	assign sweepRun = sweepRun_ff;
	assign lagSweepEnable = lagSweep_ff;
	assign lock_indication_output_bit = lockBit_ff;

	// ----------------------------------------
	// Readback status word
	// ----------------------------------------
	// Bit 3 spare; counts above the state code
	localparam int STATUS_PAD = 28 - 2 * CNT_WIDTH;
	assign stateWord = {STATUS_PAD'(0), sweepCount, verifyCount, 1'b0, 3'(state_ff)};

endmodule

/* dv/lkd_host_model.sv */
// Host processor model: AXI4-Lite master with one write and one read task.
// Assumes the testbench calls the tasks one at a time from one process.
module lkd_host_model
	import lkd_pkg::*;
(
	input wire logic sys_clk,
	output logic [9:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [9:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task automatic write_word(input logic [9:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= (a == LKD_ADDR_CONFIG) ? (d & 32'hffff7ffd) : d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	// No halt needed before reading under host control
	task automatic read_word(input logic [9:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
endmodule

/* dv/lkd_assertions.sv */
// Port-level checker of the lock detector top.
// Assumes binding to lkd_lock_detector, one clock, synchronous reset.
module lkd_assertions
	import lkd_pkg::*;
#(
	parameter int CNT_WIDTH = 4
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic periodEnd,
	input wire logic falseOverflow,
	input wire logic accumRun,
	input wire logic acqParamSel,
	input wire logic falseAccumEnable,
	input wire logic sweepRun,
	input wire logic lagSweepEnable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	AST_VERIFY_TRACK_SET: assert property (falseAccumEnable |-> !acqParamSel)
		else $error("false lock accumulator on with acquisition set");
	AST_VERIFY_NO_SWEEP: assert property (falseAccumEnable |-> !sweepRun && !lagSweepEnable)
		else $error("sweep active while false lock accumulator on");
	AST_LAG_NEEDS_SWEEP: assert property (lagSweepEnable |-> sweepRun)
		else $error("lag sweep without sweep block");
	AST_STOP_AT_PERIOD: assert property ($fell(accumRun) |-> $past(periodEnd) || $past(periodEnd, 2))
		else $error("accumulator stopped without period end");
	AST_FALSE_LOCK_CAUSE: assert property ($rose(lagSweepEnable) && $past(falseAccumEnable) |->
		$past(falseOverflow) || $past(falseOverflow, 2))
		else $error("false lock without overflow");
	AST_W_REFUSED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 !s_axi_bvalid)
		else $error("write response repeated");

	cover property ($fell(accumRun));
	cover property ($rose(lagSweepEnable));
	cover property (falseAccumEnable ##1 !falseAccumEnable);
endmodule

bind lkd_lock_detector lkd_assertions #(.CNT_WIDTH(CNT_WIDTH)) lkd_assertions_i (.*);

/* dv/tb_lkd_lock_detector.sv */
// Self-checking bench of the lock detector configuration block.
// Assumes lkd_host_model as bus master; expectations queued per response.
module tb_lkd_lock_detector
	import lkd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, reset, periodEnd, carrierLock, lockRollover, falseOverflow, computeTick;
	logic accumRun, acqParamSel, falseAccumEnable, sweepRun, lagSweepEnable;
	logic lock_indication_output_bit, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [9:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [65:0] rq[$], bq[$], note;
	int failures, n_compared, v, s;

	lkd_lock_detector #(.CNT_WIDTH(4)) lkd_lock_detector_i (.*);
	lkd_host_model lkd_host_model_i (.*);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tally_and_finish();
		if (failures == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp_word(string nm, logic [31:0] m, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if ((g & m) !== (e & m)) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_resp(string nm, logic [1:0] e, logic [1:0] g);
		cmp_word(nm, 32'h3, 32'(e), 32'(g));
	endtask
	task automatic cmp_bit(string nm, logic e, logic g);
		cmp_word(nm, 32'h1, 32'(e), 32'(g));
	endtask
	task automatic rd(logic [9:0] a, logic [31:0] m, logic [1:0] r, logic [31:0] d);
		rq.push_back({m, r, d});
		lkd_host_model_i.read_word(a);
	endtask
	task automatic wr(logic [9:0] a, logic [31:0] d, logic [1:0] r);
		bq.push_back({32'h0, r, 32'h0});
		lkd_host_model_i.write_word(a, d);
	endtask
	task automatic st(lkd_state_t k);
		rd(LKD_ADDR_STATE, 32'h7, 2'b00, 32'(k));
	endtask
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic pulse(logic [3:0] p);
		@(posedge sys_clk);
		{lockRollover, periodEnd, falseOverflow, computeTick} <= p;
		@(posedge sys_clk);
		{lockRollover, periodEnd, falseOverflow, computeTick} <= 4'h0;
		@(posedge sys_clk);
	endtask
	function automatic logic [31:0] cfg(logic fe, c, logic [3:0] vl, sl, logic m, a, l, w);
		cfg = {16'($urandom()), 1'b0, fe, c, vl, sl, m, a, l, 1'b0, w};
	endfunction
	task automatic go(logic fe, c, logic [3:0] vl, sl, logic l);
		wr(LKD_ADDR_CONFIG, cfg(1'b0, c, vl, sl, 1'b0, 1'b0, l, 1'b0), 2'b00);
		wr(LKD_ADDR_CONFIG, cfg(fe, c, vl, sl, 1'b1, 1'b0, l, 1'b0), 2'b00);
	endtask

	always @(posedge sys_clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			note = rq.pop_front();
			cmp_resp("rresp", note[33:32], s_axi_rresp);
			cmp_word("rdata", note[65:34], note[31:0], s_axi_rdata);
		end
		if (s_axi_bvalid && s_axi_bready) begin
			note = bq.pop_front();
			cmp_resp("bresp", note[33:32], s_axi_bresp);
		end
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		tally_and_finish();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		{periodEnd, carrierLock, lockRollover, falseOverflow, computeTick} = 5'h00;
		void'($urandom(32'hf67beda0));
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		rd(LKD_ADDR_CONFIG, 32'h0, 2'b10, 32'h0);
		rd(10'h3fc, 32'hffffffff, 2'b10, 32'h0);
		wr(10'h3fc, 32'h0, 2'b10);
		for (int i = 0; i < 8; i++) begin
			wr(LKD_ADDR_CONFIG, cfg(i[2], 1'b0, 4'h0, 4'h0, 1'b0, i[2], i[1], i[0]), 2'b00);
			settle();
			cmp_bit("acqParamSel", i[2], acqParamSel);
			cmp_bit("lockBit", i[1], lock_indication_output_bit);
			cmp_bit("lagSweepEnable", i[0], lagSweepEnable);
			cmp_bit("sweepRun", i[0], sweepRun);
			cmp_bit("falseAccumEnable", 1'b0, falseAccumEnable);
		end
		st(LKD_HOST_RUN);
		pulse(4'h8);
		st(LKD_HOST_RUN);
		pulse(4'h4);
		settle();
		cmp_bit("accumRun", 1'b0, accumRun);
		st(LKD_HOST_STOP);
		wr(LKD_ADDR_CMD, 32'h1, 2'b00);
		st(LKD_HOST_RUN);
		go(1'b0, 1'b1, 4'h0, 4'h0, 1'b1);
		st(LKD_LOCKED);
		cmp_bit("lockBit", 1'b1, lock_indication_output_bit);
		v = $urandom_range(4, 2);
		go(1'b0, 1'b1, 4'(v), 4'h2, 1'b0);
		st(LKD_ACQUIRE);
		cmp_bit("lockBit", 1'b0, lock_indication_output_bit);
		carrierLock <= 1'b1;
		pulse(4'h4);
		st(LKD_VERIFY);
		cmp_bit("acqParamSel", 1'b0, acqParamSel);
		pulse(4'h2);
		st(LKD_VERIFY);
		repeat (v - 1) pulse(4'h4);
		st(LKD_VERIFY);
		pulse(4'h4);
		st(LKD_LOCKED);
		for (int c = 1; c >= 0; c--) begin
			s = $urandom_range(3, 2);
			go(1'b1, c[0], 4'h4, 4'(s), 1'b0);
			pulse(4'h4);
			settle();
			cmp_bit("falseAccumEnable", 1'b1, falseAccumEnable);
			pulse(4'h2);
			st(LKD_FALSE_LOCK);
			repeat (s - 1) pulse(c ? 4'h4 : 4'h1);
			st(LKD_FALSE_LOCK);
			settle();
			cmp_bit("lagSweepEnable", !c[0], lagSweepEnable);
			pulse(c ? 4'h4 : 4'h1);
			settle();
			cmp_bit("lagSweepEnable", 1'b0, lagSweepEnable);
			if (c != 0) st(LKD_ACQUIRE);
		end
		repeat (4) @(posedge sys_clk);
		if (rq.size() + bq.size() != 0) failures++;
		tally_and_finish();
	end
endmodule
